/* File: inc/cpu_init_pkg.sv */
// constants, register map and types of the reset and initialization block
package cpu_init_pkg;
    localparam logic [7:0]  OFF_ACCUM        = 8'h00;
    localparam logic [7:0]  OFF_DATA         = 8'h04;
    localparam logic [7:0]  OFF_CMD          = 8'h08;
    localparam logic [7:0]  OFF_MODEL_IDX    = 8'h0c;
    localparam logic [7:0]  OFF_CTRL4        = 8'h10;
    localparam logic [7:0]  OFF_VECTOR_CSR   = 8'h14;
    localparam logic [7:0]  OFF_TABLE_BASE   = 8'h18;
    localparam logic [7:0]  OFF_FETCH_ADDR   = 8'h1c;
    localparam logic [7:0]  OFF_MODE         = 8'h20;
    localparam logic [7:0]  OFF_INT_STATUS   = 8'h24;
    localparam logic [7:0]  OFF_INT_CLEAR    = 8'h28;
    localparam logic [7:0]  OFF_INT_ENABLE   = 8'h2c;
    localparam logic [7:0]  OFF_NMI_STATE    = 8'h30;
    localparam int          CMD_IDENT        = 0;
    localparam int          CMD_MODEL_READ   = 1;
    localparam int          CMD_MODEL_WRITE  = 2;
    localparam int          CMD_TABLE_LOAD   = 3;
    localparam int          CMD_NMI_RETURN   = 4;
    localparam int          EV_NMI_TAKEN     = 0;
    localparam int          EV_NMI_HELD      = 1;
    localparam int          EV_CMD_DONE      = 2;
    localparam int          EV_BAD_INDEX     = 3;
    localparam int          EV_W             = 4;
    localparam int          FEAT_LINE_FLUSH  = 19;
    localparam int          FEAT_STATE_SAVE  = 24;
    localparam int          FEAT_VECTOR      = 25;
    localparam int          FEAT_VECTOR_V2   = 26;
    localparam logic [31:0] FEATURE_WORD     = (32'h1 << FEAT_LINE_FLUSH) | (32'h1 << FEAT_STATE_SAVE)
                                             | (32'h1 << FEAT_VECTOR) | (32'h1 << FEAT_VECTOR_V2);
    localparam logic [31:0] IDENT_FEATURE_LEAF = 32'h0000_0001;
    localparam int          CTRL4_STATE_SAVE = 9;
    localparam int          CTRL4_SIMD_FAULT = 10;
    localparam logic [31:0] CTRL4_MASK       = (32'h1 << CTRL4_STATE_SAVE) | (32'h1 << CTRL4_SIMD_FAULT);
    localparam logic [31:0] RESET_FETCH_ADDR = 32'hffff_fff0;
    localparam logic [31:0] RESET_TABLE_BASE = 32'h0000_0000;
    localparam logic [31:0] RESET_VECTOR_CSR = 32'h0000_0000;
    localparam int          MODEL_REG_COUNT  = 8;
    localparam int          MODEL_IDX_W      = 3;
    localparam logic [7:0]  MODEL_IDX_LIMIT  = 8'h08;
    localparam int          MEM_TYPE_COUNT   = 4;
    localparam int          MEM_TYPE_LSB     = 0;
    localparam int          MEM_TYPE_MSB     = 2;
    localparam logic [2:0]  MEM_TYPE_UNCACHED = 3'h0;
    typedef enum logic [1:0]
    {
        NMI_IDLE    = 2'b01,
        NMI_SERVICE = 2'b10
    } nmi_state_e;
endpackage

/* File: inc/nmi_if.sv */
// signals between the register core and the non-maskable interrupt acceptor
`timescale 1ns/1ps
interface nmi_if;
    logic raw;
    logic ret;
    logic take;
    logic busy;
    logic held;
    logic pend;
    modport ctrl (input raw, input ret, output take, output busy, output held, output pend);
    modport core (output raw, output ret, input take, input busy, input held, input pend);
endinterface

/* File: core/nmi_acceptor.sv */
// non-maskable interrupt acceptor with hold-off while one is in service
`timescale 1ns/1ps
module nmi_acceptor
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    nmi_if.ctrl       nmi
);
    import cpu_init_pkg::*;

    nmi_state_e state;
    nmi_state_e next_state;
    logic       raw_q;
    logic       pend;
    logic       next_pend;
    logic       take;
    logic       next_take;
    logic       held;
    logic       next_held;
    logic       rise;

    assign rise = nmi.raw & ~raw_q;

    ////////////////////////////////////////////////////////////////////////
    // no mask bit exists; only an active service defers a new request
    always_comb
    begin
        next_state = state;
        next_pend  = pend;
        next_take  = 1'b0;
        next_held  = 1'b0;
        case (state)
            NMI_IDLE:
            begin
                if (rise || pend)
                begin
                    next_take  = 1'b1;
                    next_pend  = 1'b0;
                    next_state = NMI_SERVICE;
                end
            end
            NMI_SERVICE:
            begin
                if (nmi.ret)
                    next_state = NMI_IDLE;
                // set wins: an edge with the return is kept pending
                if (rise)
                begin
                    next_pend = 1'b1;
                    next_held = 1'b1;
                end
            end
            default:
                next_state = NMI_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            state <= NMI_IDLE;
            raw_q <= 1'b0;
            pend  <= 1'b0;
            take  <= 1'b0;
            held  <= 1'b0;
        end
        else
        begin
            state <= next_state;
            raw_q <= nmi.raw;
            pend  <= next_pend;
            take  <= next_take;
            held  <= next_held;
        end
    end

    assign nmi.take = take;
    assign nmi.held = held;
    assign nmi.pend = pend;
    assign nmi.busy = (state == NMI_SERVICE);

    ////////////////////////////////////////////////////////////////////////
    AST_NMI_ALWAYS_TAKEN: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        (state == NMI_IDLE) && !pend && rise |=> take && nmi.busy)
        else $error("idle nmi edge not taken next cycle");
    AST_NMI_HOLD_OFF: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        nmi.busy && !nmi.ret && rise |=> !take && pend && held ##1 !take)
        else $error("nmi taken while one is in service");
endmodule

/* File: core/cpu_init_core.sv */
// reset state, identification, control and model registers behind an apb slave
//
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ps
module cpu_init_core
(
    input  wire logic        ref_clk_i,
    input  wire logic        resetn_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic        nmi_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    output logic             real_mode_o,
    output logic [31:0]      fetch_addr_o,
    output logic [31:0]      table_base_o,
    output logic             os_ext_state_save_enable_o,
    output logic             os_simd_fp_fault_enable_o,
    output logic [31:0]      vector_csr_o,
    output logic [cpu_init_pkg::MEM_TYPE_COUNT-1:0] mem_uncached_o,
    output logic             nmi_take_o,
    output logic             nmi_busy_o
);
    import cpu_init_pkg::*;

    nmi_if nmi ();

    logic [31:0]           accum;
    logic [31:0]           next_accum;
    logic [31:0]           data_word;
    logic [31:0]           next_data_word;
    logic [7:0]            model_idx;
    logic [7:0]            next_model_idx;
    logic [31:0]           model_regs      [MODEL_REG_COUNT];
    logic [31:0]           next_model_regs [MODEL_REG_COUNT];
    logic [31:0]           ctrl4;
    logic [31:0]           next_ctrl4;
    logic [31:0]           vector_csr;
    logic [31:0]           next_vector_csr;
    logic [31:0]           table_base;
    logic [31:0]           next_table_base;
    logic [31:0]           fetch_addr;
    logic                  real_mode;
    logic [EV_W-1:0]       int_status;
    logic [EV_W-1:0]       next_int_status;
    logic [EV_W-1:0]       int_enable;
    logic [EV_W-1:0]       next_int_enable;
    logic [EV_W-1:0]       events;
    logic [31:0]           rdata;
    logic [31:0]           next_rdata;
    logic                  slverr;
    logic                  next_slverr;
    logic                  setup;
    logic                  wr_en;
    logic                  cmd_wr;
    logic                  idx_ok;
    logic                  nmi_ret;
    logic [MODEL_IDX_W-1:0] sel_idx;
    logic [31:0]           sel_model;

    ////////////////////////////////////////////////////////////////////////
    // apb decode; zero wait states, so pready is just the access phase
    assign setup    = psel_i & ~penable_i;
    assign wr_en    = psel_i & penable_i & pwrite_i;
    assign cmd_wr   = wr_en && (paddr_i == OFF_CMD);
    assign pready_o = psel_i & penable_i;
    assign pslverr_o = slverr & psel_i & penable_i;
    assign prdata_o = rdata;
    assign idx_ok   = (model_idx < MODEL_IDX_LIMIT);
    assign sel_idx  = model_idx[MODEL_IDX_W-1:0];
    assign sel_model = model_regs[sel_idx];
    assign nmi_ret  = cmd_wr && pwdata_i[CMD_NMI_RETURN];

    ////////////////////////////////////////////////////////////////////////
    // read data is latched in the setup phase; the master holds the address
    always_comb
    begin
        next_rdata  = rdata;
        next_slverr = slverr;
        if (setup)
        begin
            next_slverr = 1'b0;
            next_rdata  = 32'h0000_0000;
            case (paddr_i)
                OFF_ACCUM:      next_rdata = accum;
                OFF_DATA:       next_rdata = data_word;
                OFF_CMD:        next_rdata = 32'h0000_0000;
                OFF_MODEL_IDX:  next_rdata = {24'h00_0000, model_idx};
                OFF_CTRL4:      next_rdata = ctrl4;
                OFF_VECTOR_CSR: next_rdata = vector_csr;
                OFF_TABLE_BASE: next_rdata = table_base;
                OFF_FETCH_ADDR: next_rdata = fetch_addr;
                OFF_MODE:       next_rdata = {31'h0, real_mode};
                OFF_INT_STATUS: next_rdata = {{(32-EV_W){1'b0}}, int_status};
                OFF_INT_CLEAR:  next_rdata = 32'h0000_0000;
                OFF_INT_ENABLE: next_rdata = {{(32-EV_W){1'b0}}, int_enable};
                OFF_NMI_STATE:  next_rdata = {30'h0, nmi.pend, nmi.busy};
                default:        next_slverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            rdata  <= 32'h0000_0000;
            slverr <= 1'b0;
        end
        else
        begin
            rdata  <= next_rdata;
            slverr <= next_slverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // software registers and the commands that act on them
    always_comb
    begin
        next_accum      = accum;
        next_data_word  = data_word;
        next_model_idx  = model_idx;
        next_model_regs = model_regs;
        next_ctrl4      = ctrl4;
        next_vector_csr = vector_csr;
        next_table_base = table_base;
        next_int_enable = int_enable;
        if (wr_en)
        begin
            case (paddr_i)
                OFF_ACCUM:      next_accum = pwdata_i;
                OFF_MODEL_IDX:  next_model_idx = pwdata_i[7:0];
                OFF_CTRL4:      next_ctrl4 = pwdata_i & CTRL4_MASK;
                OFF_VECTOR_CSR: next_vector_csr = pwdata_i;
                OFF_INT_ENABLE: next_int_enable = pwdata_i[EV_W-1:0];
                default:        next_accum = accum;
            endcase
        end
        if (cmd_wr)
        begin
            if (pwdata_i[CMD_IDENT])
                next_data_word = (accum == IDENT_FEATURE_LEAF) ? FEATURE_WORD : 32'h0000_0000;
            // a model read in the same write overrides the identification result
            if (pwdata_i[CMD_MODEL_READ] && idx_ok)
                next_data_word = sel_model;
            if (pwdata_i[CMD_MODEL_WRITE] && idx_ok)
                next_model_regs[sel_idx] = accum;
            if (pwdata_i[CMD_TABLE_LOAD])
                next_table_base = accum;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            accum      <= 32'h0000_0000;
            data_word  <= 32'h0000_0000;
            model_idx  <= 8'h00;
            ctrl4      <= 32'h0000_0000;
            vector_csr <= RESET_VECTOR_CSR;
            table_base <= RESET_TABLE_BASE;
            int_enable <= {EV_W{1'b0}};
            // zero in every model register leaves each range uncached
            for (int i = 0; i < MODEL_REG_COUNT; i++)
                model_regs[i] <= 32'h0000_0000;
        end
        else
        begin
            accum      <= next_accum;
            data_word  <= next_data_word;
            model_idx  <= next_model_idx;
            ctrl4      <= next_ctrl4;
            vector_csr <= next_vector_csr;
            table_base <= next_table_base;
            int_enable <= next_int_enable;
            model_regs <= next_model_regs;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // reset state: protected mode is out of scope, so real mode never ends
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            real_mode  <= 1'b1;
            fetch_addr <= RESET_FETCH_ADDR;
        end
        else
        begin
            real_mode  <= real_mode;
            fetch_addr <= fetch_addr;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sticky events; a set in the clearing cycle survives
    always_comb
    begin
        events = {EV_W{1'b0}};
        events[EV_NMI_TAKEN] = nmi.take;
        events[EV_NMI_HELD]  = nmi.held;
        events[EV_CMD_DONE]  = cmd_wr && (pwdata_i != 32'h0000_0000);
        events[EV_BAD_INDEX] = cmd_wr && !idx_ok && (pwdata_i[CMD_MODEL_READ] || pwdata_i[CMD_MODEL_WRITE]);
        next_int_status = int_status;
        if (wr_en && (paddr_i == OFF_INT_CLEAR))
            next_int_status = int_status & ~pwdata_i[EV_W-1:0];
        next_int_status = next_int_status | events;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            int_status <= {EV_W{1'b0}};
        else
            int_status <= next_int_status;
    end

    assign irq_o = |(int_status & int_enable);

    ////////////////////////////////////////////////////////////////////////
    // memory type decode per range register
    generate
        for (genvar g = 0; g < MEM_TYPE_COUNT; g++)
        begin : g_mem_type
            assign mem_uncached_o[g] = (model_regs[g][MEM_TYPE_MSB:MEM_TYPE_LSB] == MEM_TYPE_UNCACHED);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // the pin feeds the acceptor ungated; any masking is board logic
    assign nmi.raw = nmi_i;
    assign nmi.ret = nmi_ret;

    nmi_acceptor u_nmi
    (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .nmi       (nmi.ctrl)
    );

    assign nmi_take_o                 = nmi.take;
    assign nmi_busy_o                 = nmi.busy;
    assign real_mode_o                = real_mode;
    assign fetch_addr_o               = fetch_addr;
    assign table_base_o               = table_base;
    assign os_ext_state_save_enable_o = ctrl4[CTRL4_STATE_SAVE];
    assign os_simd_fp_fault_enable_o  = ctrl4[CTRL4_SIMD_FAULT];
    assign vector_csr_o               = vector_csr;

    ////////////////////////////////////////////////////////////////////////
    AST_IDENT_LOAD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cmd_wr && pwdata_i[CMD_IDENT] && !pwdata_i[CMD_MODEL_READ] && (accum == IDENT_FEATURE_LEAF)
        |=> data_word == FEATURE_WORD)
        else $error("identification did not load feature word");
    AST_FEATURE_BITS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cmd_wr && pwdata_i[CMD_IDENT] && !pwdata_i[CMD_MODEL_READ] && (accum == IDENT_FEATURE_LEAF)
        |=> data_word[FEAT_VECTOR] && data_word[FEAT_VECTOR_V2] && data_word[FEAT_STATE_SAVE]
        && data_word[FEAT_LINE_FLUSH])
        else $error("feature bits missing");
    AST_MODEL_READ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cmd_wr && pwdata_i[CMD_MODEL_READ] && !pwdata_i[CMD_MODEL_WRITE] && idx_ok
        |=> data_word == $past(sel_model))
        else $error("model register read wrong");
    AST_MODEL_WRITE: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cmd_wr && pwdata_i[CMD_MODEL_WRITE] && idx_ok
        |=> model_regs[$past(sel_idx)] == $past(accum))
        else $error("model register write lost");
    AST_UNCACHED_AT_RESET: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> mem_uncached_o == {MEM_TYPE_COUNT{1'b1}})
        else $error("ranges not uncached after reset");
    AST_RESET_FETCH: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        $rose(resetn_i) |-> (fetch_addr_o == RESET_FETCH_ADDR) && real_mode_o && (table_base_o == RESET_TABLE_BASE))
        else $error("reset state wrong");
    AST_TABLE_LOAD: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        cmd_wr && pwdata_i[CMD_TABLE_LOAD] |=> table_base_o == $past(accum))
        else $error("table base not reloaded");
    AST_CTRL4_BITS: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        wr_en && (paddr_i == OFF_CTRL4) |=> (os_ext_state_save_enable_o == $past(pwdata_i[CTRL4_STATE_SAVE]))
        && (os_simd_fp_fault_enable_o == $past(pwdata_i[CTRL4_SIMD_FAULT])))
        else $error("control register 4 bits wrong");
    AST_NMI_IRQ: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        nmi_take_o && int_enable[EV_NMI_TAKEN] |=> irq_o)
        else $error("enabled nmi event gave no interrupt");
endmodule

/* File: verif/nmi_gate_model.sv */
// board logic that gates the raw non-maskable request with an i/o port enable flag
`timescale 1ns/1ps
module nmi_gate_model
(
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    input  wire logic raw_nmi_i,
    input  wire logic io_wr_i,
    input  wire logic io_wdata_i,
    output logic      io_rdata_o,
    output logic      nmi_o
);
    logic flag;
    logic next_flag;
    ////////////////////////////////////////////////////////////////////////////////
    // one writable bit at a fixed port; reset wins so firmware starts with nmi held away
    always_comb
    begin
        next_flag = io_wr_i ? io_wdata_i : flag;
    end
    always_ff @(posedge ref_clk_i)
    begin
        flag <= resetn_i ? next_flag : 1'b0;
    end
    assign io_rdata_o = flag;
    assign nmi_o      = raw_nmi_i & flag;
endmodule

/* File: verif/cpu_reset_init_nmi_gate_tb.sv */
// apb-driven bench for the reset and initialization block with board nmi gate
`timescale 1ns/1ps
module cpu_reset_init_nmi_gate_tb;
    import cpu_init_pkg::*;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, raw = 0, io_wr = 0, io_wd = 0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, vcsr, tbase, faddr, q;
    logic        pready, pslverr, irq, rmode, os_save, os_simd, take, busy, io_rd, nmi, e;
    logic [3:0]  unc;
    int          errors = 0, compares = 0, cycles = 0, takes = 0;
    always #5 clk = ~clk;
    cpu_init_core i_dut (.ref_clk_i(clk), .resetn_i(rstn), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .nmi_i(nmi), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .real_mode_o(rmode), .fetch_addr_o(faddr),
        .table_base_o(tbase), .os_ext_state_save_enable_o(os_save), .os_simd_fp_fault_enable_o(os_simd),
        .vector_csr_o(vcsr), .mem_uncached_o(unc), .nmi_take_o(take), .nmi_busy_o(busy));
    nmi_gate_model i_gate (.ref_clk_i(clk), .resetn_i(rstn), .raw_nmi_i(raw), .io_wr_i(io_wr),
        .io_wdata_i(io_wd), .io_rdata_o(io_rd), .nmi_o(nmi));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tally_and_finish();
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one idle cycle after release so psel never gets two assignments in one step
    // no local limit: only the bench timeout ends a stalled access
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(q & m, exp);
    endtask
    task automatic cmd(input int c);
        wr(OFF_CMD, 32'h1 << c);
    endtask
    task automatic pulse();
        raw <= 1'b1;
        repeat (3) @(posedge clk);
        raw <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clk)
    begin
        cycles++;
        if (take === 1'b1)
            takes++;
        if (cycles >= 5000)
        begin
            errors++;
            tally_and_finish();
        end
    end
    initial
    begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(rmode, 1'b1);
        chk(faddr, 32'hffff_fff0);
        chk(tbase, 32'h0);
        chk(unc, 4'hf);
        chk({os_save, os_simd}, 2'b00);
        chk(vcsr, 32'h0);
        rd(OFF_FETCH_ADDR, 32'hffff_ffff, 32'hffff_fff0);
        rd(OFF_MODE, 32'h1, 32'h1);
        wr(OFF_ACCUM, 32'h1);
        cmd(CMD_IDENT);
        rd(OFF_DATA, 32'hffff_ffff, 32'h0708_0000);
        wr(OFF_ACCUM, 32'h2);
        cmd(CMD_IDENT);
        rd(OFF_DATA, 32'hffff_ffff, 32'h0);
        wr(OFF_CTRL4, 32'hffff_ffff);
        rd(OFF_CTRL4, 32'hffff_ffff, 32'h0000_0600);
        chk({os_save, os_simd}, 2'b11);
        wr(OFF_VECTOR_CSR, 32'h0000_1f80);
        rd(OFF_VECTOR_CSR, 32'hffff_ffff, 32'h0000_1f80);
        chk(vcsr, 32'h0000_1f80);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFF_MODEL_IDX, i);
            wr(OFF_ACCUM, 32'hc0de_0000 | i);
            cmd(CMD_MODEL_WRITE);
        end
        chk(unc, 4'h1);
        for (int i = 0; i < 8; i++)
        begin
            wr(OFF_MODEL_IDX, i);
            cmd(CMD_MODEL_READ);
            rd(OFF_DATA, 32'hffff_ffff, 32'hc0de_0000 | i);
        end
        wr(OFF_ACCUM, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(OFF_MODEL_IDX, i);
            cmd(CMD_MODEL_WRITE);
        end
        chk(unc, 4'hf);
        wr(OFF_MODEL_IDX, 32'h8);
        cmd(CMD_MODEL_READ);
        rd(OFF_INT_STATUS, 32'h1 << EV_BAD_INDEX, 32'h1 << EV_BAD_INDEX);
        wr(OFF_ACCUM, 32'h0001_2340);
        cmd(CMD_TABLE_LOAD);
        rd(OFF_TABLE_BASE, 32'hffff_ffff, 32'h0001_2340);
        apb(1'b0, 8'h40, 32'h0);
        chk(e, 1'b1);
        chk(q, 32'h0);
        // gate flag is clear after reset, so a raw request must not reach the core
        pulse();
        chk(takes, 32'h0);
        chk(busy, 1'b0);
        io_wr <= 1'b1; io_wd <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        @(posedge clk);
        chk(io_rd, 1'b1);
        pulse();
        chk(takes, 32'h1);
        chk(busy, 1'b1);
        pulse();
        chk(takes, 32'h1);
        rd(OFF_NMI_STATE, 32'h3, 32'h3);
        // table base is loaded, so the interrupt may be enabled now
        wr(OFF_INT_ENABLE, 32'h1 << EV_NMI_TAKEN);
        cmd(CMD_NMI_RETURN);
        repeat (3) @(posedge clk);
        chk(takes, 32'h2);
        chk(busy, 1'b1);
        chk(irq, 1'b1);
        cmd(CMD_NMI_RETURN);
        chk(busy, 1'b0);
        rd(OFF_INT_STATUS, 32'h3, 32'h3);
        wr(OFF_INT_ENABLE, 32'h0);
        chk(irq, 1'b0);
        wr(OFF_INT_ENABLE, 32'h1 << EV_NMI_TAKEN);
        chk(irq, 1'b1);
        wr(OFF_INT_CLEAR, 32'h1 << EV_NMI_TAKEN);
        chk(irq, 1'b0);
        rd(OFF_INT_STATUS, 32'h3, 32'h2);
        // mid-run reset: gate flag and table base must return to idle
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk(io_rd, 1'b0);
        chk(tbase, 32'h0);
        chk(rmode, 1'b1);
        chk(unc, 4'hf);
        chk(irq, 1'b0);
        tally_and_finish();
    end
endmodule
